// >>> common/brseq_regs.svh
`ifndef BRSEQ_REGS_SVH
`define BRSEQ_REGS_SVH

// register byte offsets
`define BRSEQ_ADR_IBR      8'h00
`define BRSEQ_ADR_SHADOW   8'h04
`define BRSEQ_ADR_LINK     8'h08
`define BRSEQ_ADR_ESS      8'h0c
`define BRSEQ_ADR_STATUS   8'h10

// reset values
`define BRSEQ_SEG_RST      5'h00
`define BRSEQ_SHADOW_RST   16'h0000
`define BRSEQ_LINK_RST     17'h00000
`define BRSEQ_ADDR_RST     17'h00000
`define BRSEQ_CSO_RST      8'h00

// instruction fields
`define BRSEQ_OPC_HI       31
`define BRSEQ_OPC_LO       26
`define BRSEQ_ESS_HI       25
`define BRSEQ_ESS_LO       22
`define BRSEQ_SENSE_BIT    21
`define BRSEQ_COND_BIT     20
`define BRSEQ_CSO_HI       19
`define BRSEQ_CSO_LO       12
`define BRSEQ_TGT_HI       11
`define BRSEQ_TGT_LO       0

// branch opcodes
`define BRSEQ_OP_BIMM      6'h20
`define BRSEQ_OP_BIMM_L    6'h21
`define BRSEQ_OP_BSHD      6'h22
`define BRSEQ_OP_BSHD_L    6'h23
`define BRSEQ_OP_BREG      6'h24
`define BRSEQ_OP_BREG_L    6'h25

// condition select codes
`define BRSEQ_ESS_ICA      0
`define BRSEQ_ESS_ICB      1
`define BRSEQ_ESS_TXF_LE   2
`define BRSEQ_ESS_RXB_GE   3
`define BRSEQ_ESS_ACF      4
`define BRSEQ_ESS_SCHED    5
`define BRSEQ_ESS_CIN      6
`define BRSEQ_ESS_COUT     7
`define BRSEQ_ESS_SPARSE   8
`define BRSEQ_ESS_RXB_GT   9
`define BRSEQ_ESS_TXF_MAX  10
`define BRSEQ_ESS_DMA_OQ   11
`define BRSEQ_ESS_DMA_Q    13
`define BRSEQ_ESS_RSVD     15
`define BRSEQ_ESS_UNCOND   4'hf

// counter thresholds
`define BRSEQ_TXF_LIMIT    4'h2
`define BRSEQ_RXB_LIMIT    4'h4
`define BRSEQ_RXB_EMPTY    4'h0
`define BRSEQ_TXF_FULL     4'hf

// address steps
`define BRSEQ_SLOT_STEP    17'h00001
`define BRSEQ_LINK_STEP    17'h00002

`endif

// >>> common/brseq_pkg.sv
package brseq_pkg;
	typedef logic [4:0]  brseq_seg_t;
	typedef logic [11:0] brseq_tgt_t;
	typedef logic [16:0] brseq_iaddr_t;
	typedef logic [3:0]  brseq_cnt_t;
	typedef logic [15:0] brseq_ess_t;
	typedef logic [31:0] brseq_word_t;
	typedef enum logic [1:0] {
		BRSEQ_TSRC_IMM    = 2'h0,
		BRSEQ_TSRC_SHADOW = 2'h1,
		BRSEQ_TSRC_LINK   = 2'h3
	} brseq_tsrc_t;
	typedef enum logic [1:0] {
		BRSEQ_WB_IDLE = 2'h0,
		BRSEQ_WB_ACK  = 2'h1
	} brseq_wbst_t;
endpackage

// >>> common/brseq_cond_if.sv
`timescale 1ns/1ps
interface brseq_cond_if;
	import brseq_pkg::*;
	brseq_ess_t essVec;
	logic [3:0] select;
	logic       condBit;
	logic       uncond;
	modport sel  (input select, output essVec, output condBit, output uncond);
	modport user (output select, input essVec, input condBit, input uncond);
endinterface

// >>> rtl/brseq_cond_sel.sv
`timescale 1ns/1ps
`include "brseq_regs.svh"
module brseq_cond_sel (
	input  wire logic                 interchipA,
	input  wire logic                 interchipB,
	input  wire logic                 coprocInBusy,
	input  wire logic                 coprocOutReady,
	input  wire logic                 assignedCell,
	input  wire logic                 schedBusy,
	input  wire brseq_pkg::brseq_ess_t sparseEvents,
	input  wire brseq_pkg::brseq_cnt_t transmitFullCount,
	input  wire brseq_pkg::brseq_cnt_t receiveBusyCount,
	input  wire logic [1:0]           dmaOutBusy,
	input  wire logic [1:0]           dmaQueueBusy,
	brseq_cond_if.sel                 condBus
);
	import brseq_pkg::*;

	wire [15:0] essBits;

	assign essBits[`BRSEQ_ESS_ICA]     = interchipA;
	assign essBits[`BRSEQ_ESS_ICB]     = interchipB;
	assign essBits[`BRSEQ_ESS_CIN]     = coprocInBusy;
	assign essBits[`BRSEQ_ESS_COUT]    = coprocOutReady;
	assign essBits[`BRSEQ_ESS_ACF]     = assignedCell;
	assign essBits[`BRSEQ_ESS_SCHED]   = schedBusy;
	assign essBits[`BRSEQ_ESS_SPARSE]  = |sparseEvents;
	assign essBits[`BRSEQ_ESS_TXF_LE]  = transmitFullCount <= `BRSEQ_TXF_LIMIT;
	assign essBits[`BRSEQ_ESS_RXB_GE]  = receiveBusyCount >= `BRSEQ_RXB_LIMIT;
	assign essBits[`BRSEQ_ESS_RXB_GT]  = receiveBusyCount > `BRSEQ_RXB_EMPTY;
	assign essBits[`BRSEQ_ESS_TXF_MAX] = transmitFullCount == `BRSEQ_TXF_FULL;
	assign essBits[`BRSEQ_ESS_RSVD]    = 1'b0;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : gDma
			assign essBits[`BRSEQ_ESS_DMA_OQ + ch] = dmaOutBusy[ch] | dmaQueueBusy[ch];
			assign essBits[`BRSEQ_ESS_DMA_Q + ch]  = dmaQueueBusy[ch];
		end
	endgenerate

	assign condBus.essVec  = essBits;
	assign condBus.uncond  = condBus.select == `BRSEQ_ESS_UNCOND;
	assign condBus.condBit = essBits[condBus.select];
endmodule // brseq_cond_sel

// >>> rtl/branch_sequencer.sv
// Function
// - destination is segment id joined with target
// - 128K instruction space, 32 segments of 4K
// - 5-bit segment changes only on software write
// - target field is absolute word in segment
// - immediate forms take instruction bits 11:0
// - shadow forms take shadow register bits 11:0
// - shadow loads first halfword of linked read
// - register forms take link register bits 11:0
// - condition select picks one external state bit
// - select 1111 means unconditional branch
// - codes 0,1,4-7 map single state inputs, 8 ORs sparse events
// - codes 2,3,9,10 compare the counters with limits
// - codes 11-14 test dma channel busy stages
// - taken when condition bit equals sense bit
// - committed slot always fetched, no bubble
// - taken: slot runs, then branch target
// - not taken: slot squashed if conditional set
// - unconditional: conditional bit nullifies the slot
// - link written only if taken, address plus two
// - counter operation issued whether taken or not
`timescale 1ns/1ps
`include "brseq_regs.svh"
module branch_sequencer (
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	input  wire logic [7:0]             adr_i,
	input  wire brseq_pkg::brseq_word_t dat_i,
	output logic [31:0]                 dat_o,
	input  wire logic                   we_i,
	input  wire logic [3:0]             sel_i,
	input  wire logic                   stb_i,
	input  wire logic                   cyc_i,
	output logic                        ack_o,
	input  wire logic                   issueValid,
	input  wire brseq_pkg::brseq_word_t issueInstr,
	input  wire brseq_pkg::brseq_iaddr_t issueAddr,
	input  wire logic                   fmLinkValid,
	input  wire logic [15:0]            fmFirstHalf,
	input  wire logic                   interchipA,
	input  wire logic                   interchipB,
	input  wire logic                   coprocInBusy,
	input  wire logic                   coprocOutReady,
	input  wire logic                   assignedCell,
	input  wire logic                   schedBusy,
	input  wire brseq_pkg::brseq_ess_t  sparseEvents,
	input  wire brseq_pkg::brseq_cnt_t  transmitFullCount,
	input  wire brseq_pkg::brseq_cnt_t  receiveBusyCount,
	input  wire logic [1:0]             dmaOutBusy,
	input  wire logic [1:0]             dmaQueueBusy,
	output logic                        decideValid,
	output brseq_pkg::brseq_iaddr_t     slotAddr,
	output logic                        slotExecute,
	output logic                        branchTaken,
	output brseq_pkg::brseq_iaddr_t     fetchAddr,
	output logic                        csoValid,
	output logic [7:0]                  csoCode
);
	import brseq_pkg::*;

	function automatic logic isBranchOp(input logic [5:0] op);
		isBranchOp = (op == `BRSEQ_OP_BIMM) || (op == `BRSEQ_OP_BIMM_L) ||
			(op == `BRSEQ_OP_BSHD) || (op == `BRSEQ_OP_BSHD_L) ||
			(op == `BRSEQ_OP_BREG) || (op == `BRSEQ_OP_BREG_L);
	endfunction

	function automatic logic isLinkOp(input logic [5:0] op);
		isLinkOp = (op == `BRSEQ_OP_BIMM_L) || (op == `BRSEQ_OP_BSHD_L) ||
			(op == `BRSEQ_OP_BREG_L);
	endfunction

	function automatic brseq_tsrc_t tgtSource(input logic [5:0] op);
		if ((op == `BRSEQ_OP_BSHD) || (op == `BRSEQ_OP_BSHD_L)) begin
			tgtSource = BRSEQ_TSRC_SHADOW;
		end else if ((op == `BRSEQ_OP_BREG) || (op == `BRSEQ_OP_BREG_L)) begin
			tgtSource = BRSEQ_TSRC_LINK;
		end else begin
			tgtSource = BRSEQ_TSRC_IMM;
		end
	endfunction

	function automatic brseq_word_t laneMerge(input brseq_word_t oldV,
		input brseq_word_t newV, input logic [3:0] lanes);
		brseq_word_t res;
		res = oldV;
		for (int b = 0; b < 4; b++) begin
			if (lanes[b]) begin
				res[b*8 +: 8] = newV[b*8 +: 8];
			end
		end
		laneMerge = res;
	endfunction

	// state
	brseq_seg_t   segReg;
	brseq_seg_t   segNext;
	logic [15:0]  shadowReg;
	logic [15:0]  shadowNext;
	brseq_iaddr_t linkReg;
	brseq_iaddr_t linkNext;
	brseq_wbst_t  wbStateReg;
	brseq_wbst_t  wbStateNext;
	logic [31:0]  rdDataReg;
	logic         decideValidReg;
	brseq_iaddr_t slotAddrReg;
	logic         slotExecReg;
	logic         takenReg;
	brseq_iaddr_t fetchAddrReg;
	logic         csoValidReg;
	logic [7:0]   csoCodeReg;

	brseq_cond_if condBus ();

	brseq_cond_sel uCondSel (
		.interchipA        (interchipA),
		.interchipB        (interchipB),
		.coprocInBusy      (coprocInBusy),
		.coprocOutReady    (coprocOutReady),
		.assignedCell      (assignedCell),
		.schedBusy         (schedBusy),
		.sparseEvents      (sparseEvents),
		.transmitFullCount (transmitFullCount),
		.receiveBusyCount  (receiveBusyCount),
		.dmaOutBusy        (dmaOutBusy),
		.dmaQueueBusy      (dmaQueueBusy),
		.condBus           (condBus)
	);

	// instruction decode
	wire [5:0]        opc       = issueInstr[`BRSEQ_OPC_HI:`BRSEQ_OPC_LO];
	wire [3:0]        essSel    = issueInstr[`BRSEQ_ESS_HI:`BRSEQ_ESS_LO];
	wire              senseBit  = issueInstr[`BRSEQ_SENSE_BIT];
	wire              condOpBit = issueInstr[`BRSEQ_COND_BIT];
	wire [7:0]        csoField  = issueInstr[`BRSEQ_CSO_HI:`BRSEQ_CSO_LO];
	wire brseq_tsrc_t tsrc      = tgtSource(opc);
	wire              issueGo   = issueValid & isBranchOp(opc);
	wire              linkForm  = isLinkOp(opc);

	assign condBus.select = essSel;

	// target field source
	wire brseq_tgt_t tgtField =
		(tsrc == BRSEQ_TSRC_SHADOW) ? shadowReg[`BRSEQ_TGT_HI:`BRSEQ_TGT_LO] :
		(tsrc == BRSEQ_TSRC_LINK)   ? linkReg[`BRSEQ_TGT_HI:`BRSEQ_TGT_LO] :
		issueInstr[`BRSEQ_TGT_HI:`BRSEQ_TGT_LO];

	wire brseq_iaddr_t targetAddr = {segReg, tgtField};
	wire brseq_iaddr_t seqAddr    = issueAddr + `BRSEQ_LINK_STEP;
	wire brseq_iaddr_t nextSlot   = issueAddr + `BRSEQ_SLOT_STEP;

	// branch decision
	wire takenNow    = condBus.uncond | (condBus.condBit == senseBit);
	wire slotExecNow = condBus.uncond ? ~condOpBit : (takenNow | ~condOpBit);
	wire linkWrHw    = issueGo & takenNow & linkForm;

	// bus decode
	wire wbReq    = cyc_i & stb_i;
	wire wbCommit = wbReq & (wbStateReg == BRSEQ_WB_ACK);
	wire wbWrite  = wbCommit & we_i;
	wire hitIbr   = adr_i == `BRSEQ_ADR_IBR;
	wire hitShd   = adr_i == `BRSEQ_ADR_SHADOW;
	wire hitLink  = adr_i == `BRSEQ_ADR_LINK;
	wire hitEss   = adr_i == `BRSEQ_ADR_ESS;
	wire hitStat  = adr_i == `BRSEQ_ADR_STATUS;

	wire [31:0] statusWord = {12'h000, fetchAddrReg, 1'b0, slotExecReg, takenReg};
	wire [31:0] rdMux =
		hitIbr  ? {27'h0000000, segReg} :
		hitShd  ? {16'h0000, shadowReg} :
		hitLink ? {15'h0000, linkReg} :
		hitEss  ? {16'h0000, condBus.essVec} :
		hitStat ? statusWord : 32'h00000000;

	wire brseq_word_t ibrMerge  = laneMerge({27'h0000000, segReg}, dat_i, sel_i);
	wire brseq_word_t shdMerge  = laneMerge({16'h0000, shadowReg}, dat_i, sel_i);
	wire brseq_word_t linkMerge = laneMerge({15'h0000, linkReg}, dat_i, sel_i);

	// segment changes by software write only
	assign segNext = (wbWrite & hitIbr) ? ibrMerge[4:0] : segReg;

	// hardware load of the shadow wins over a bus write
	assign shadowNext = fmLinkValid ? fmFirstHalf :
		(wbWrite & hitShd) ? shdMerge[15:0] : shadowReg;

	// a taken linking branch wins over a bus write
	assign linkNext = linkWrHw ? seqAddr :
		(wbWrite & hitLink) ? linkMerge[16:0] : linkReg;

	// bus handshake states
	always_comb begin
		case (wbStateReg)
			BRSEQ_WB_IDLE: wbStateNext = wbReq ? BRSEQ_WB_ACK : BRSEQ_WB_IDLE;
			BRSEQ_WB_ACK:  wbStateNext = BRSEQ_WB_IDLE;
			default:       wbStateNext = BRSEQ_WB_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			segReg     <= `BRSEQ_SEG_RST;
			shadowReg  <= `BRSEQ_SHADOW_RST;
			linkReg    <= `BRSEQ_LINK_RST;
			wbStateReg <= BRSEQ_WB_IDLE;
			rdDataReg  <= 32'h00000000;
		end else begin
			segReg     <= segNext;
			shadowReg  <= shadowNext;
			linkReg    <= linkNext;
			wbStateReg <= wbStateNext;
			rdDataReg  <= rdMux;
		end
	end

	// decision outputs, one cycle after issue
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			decideValidReg <= 1'b0;
			slotAddrReg    <= `BRSEQ_ADDR_RST;
			slotExecReg    <= 1'b0;
			takenReg       <= 1'b0;
			fetchAddrReg   <= `BRSEQ_ADDR_RST;
		end else begin
			decideValidReg <= issueGo;
			if (issueGo) begin
				slotAddrReg  <= nextSlot;
				slotExecReg  <= slotExecNow;
				takenReg     <= takenNow;
				fetchAddrReg <= takenNow ? targetAddr : seqAddr;
			end
		end
	end

	// counter operation goes out on every branch with a nonzero code
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			csoValidReg <= 1'b0;
			csoCodeReg  <= `BRSEQ_CSO_RST;
		end else begin
			csoValidReg <= issueGo & (csoField != `BRSEQ_CSO_RST);
			if (issueGo) begin
				csoCodeReg <= csoField;
			end
		end
	end

	assign ack_o       = wbStateReg == BRSEQ_WB_ACK;
	assign dat_o       = rdDataReg;
	assign decideValid = decideValidReg;
	assign slotAddr    = slotAddrReg;
	assign slotExecute = slotExecReg;
	assign branchTaken = takenReg;
	assign fetchAddr   = fetchAddrReg;
	assign csoValid    = csoValidReg;
	assign csoCode     = csoCodeReg;

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence sIssueTaken;
		issueGo && takenNow;
	endsequence

	sequence sIssueNotTaken;
		issueGo && !takenNow;
	endsequence

	sequence sDecided;
		decideValid ##1 !decideValid;
	endsequence

	target_form_a: assert property (sIssueTaken |=>
		fetchAddr == {$past(segReg), $past(tgtField)})
		else $error("taken branch target not segment plus field");

	imm_source_a: assert property (issueGo && tsrc == BRSEQ_TSRC_IMM
		&& takenNow |=> fetchAddr[11:0] == $past(issueInstr[11:0]))
		else $error("immediate target field wrong");

	shd_source_a: assert property (issueGo && tsrc == BRSEQ_TSRC_SHADOW
		&& takenNow |=> fetchAddr[11:0] == $past(shadowReg[11:0]))
		else $error("shadow target field wrong");

	slot_fetch_a: assert property (issueGo
		|=> decideValid && slotAddr == $past(issueAddr) + 17'h00001)
		else $error("committed slot not presented");

	not_taken_a: assert property (sIssueNotTaken |=>
		!branchTaken && fetchAddr == $past(issueAddr) + 17'h00002)
		else $error("fall through address wrong");

	cond_squash_a: assert property ((sIssueNotTaken and !condBus.uncond)
		|=> slotExecute == !$past(condOpBit))
		else $error("not taken slot handling wrong");

	uncond_slot_a: assert property (issueGo && essSel == 4'hf
		|=> branchTaken && slotExecute == !$past(condOpBit))
		else $error("unconditional slot handling wrong");

	sense_match_a: assert property (issueGo && essSel != 4'hf
		|=> branchTaken == ($past(condBus.essVec[essSel]) == $past(senseBit)))
		else $error("sense comparison wrong");

	link_write_a: assert property ((sIssueTaken and linkForm)
		|=> linkReg == $past(issueAddr) + 17'h00002)
		else $error("link register not written");

	link_hold_a: assert property ((sIssueNotTaken and !(wbWrite && hitLink))
		|=> $stable(linkReg))
		else $error("link register written on untaken branch");

	cso_always_a: assert property (issueGo && csoField != 8'h00
		|=> csoValid && csoCode == $past(csoField))
		else $error("counter operation dropped");

	seg_stable_a: assert property (!(wbWrite && hitIbr) |=> $stable(segReg))
		else $error("segment changed without software write");

	shadow_load_a: assert property (fmLinkValid |=> shadowReg == $past(fmFirstHalf))
		else $error("shadow not loaded from linked read");

	decide_pulse_a: assert property (!issueGo
		|=> !decideValid && !csoValid)
		else $error("decision pulse without branch");

	wb_ack_a: assert property (wbReq && !ack_o |=> ack_o ##1 !ack_o)
		else $error("bus ack not a single cycle");

	decided_seq_a: assert property (issueGo ##1 !issueGo
		|-> sDecided)
		else $error("decision did not end after one cycle");
endmodule // branch_sequencer

// >>> sim/brseq_pipe_model.sv
`timescale 1ns/1ps
module brseq_pipe_model (
	input  wire logic                    sys_clk,
	input  wire logic                    rst,
	input  wire logic                    reqValid,
	input  wire brseq_pkg::brseq_word_t  reqInstr,
	input  wire brseq_pkg::brseq_iaddr_t reqAddr,
	input  wire logic                    fmReq,
	input  wire logic [15:0]             fmData,
	output logic                         issueValid,
	output brseq_pkg::brseq_word_t       issueInstr,
	output brseq_pkg::brseq_iaddr_t      issueAddr,
	output logic                         fmLinkValid,
	output logic [15:0]                  fmFirstHalf
);
	import brseq_pkg::*;
	logic slotPend;
	// branch, then its committed slot as a plain word
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			slotPend <= 1'b0;
			issueValid <= 1'b0;
			issueInstr <= 32'h0;
			issueAddr <= 17'h0;
			fmLinkValid <= 1'b0;
			fmFirstHalf <= 16'h0;
		end else begin
			slotPend <= reqValid;
			issueValid <= reqValid | slotPend;
			fmLinkValid <= fmReq;
			fmFirstHalf <= fmReq ? fmData : ~fmFirstHalf;
			if (reqValid) begin
				issueInstr <= reqInstr;
				issueAddr <= reqAddr;
			end else if (slotPend) begin
				issueInstr <= {6'h00, ~issueInstr[25:0]};
				issueAddr <= issueAddr + 17'h1;
			end else begin
				issueInstr <= ~issueInstr;
			end
		end
	end
endmodule // brseq_pipe_model

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
	import brseq_pkg::*;
	logic         sys_clk, rst, wbWe, wbStb, wbCyc, wbAck, reqValid, issueValid, fmReq;
	logic         fmLinkValid, icA, icB, cinB, coutR, acf, sched, taken, slotX, s, c;
	logic         decideValid, slotExecute, branchTaken, csoValid;
	logic [7:0]   wbAdr, csoCode, cso;
	logic [3:0]   wbSel, condition_select;
	logic [1:0]   dOut, dQ;
	logic [2:0]   k;
	logic [15:0]  fmData, fmHalf, shadowV;
	brseq_word_t  wbDw, wbDr, reqInstr, issueInstr, q;
	brseq_iaddr_t reqAddr, issueAddr, slotAddr, fetchAddr, linkV, addr, dest;
	brseq_ess_t   sparse, ev;
	brseq_cnt_t   txf, rxb;
	brseq_seg_t   seg;
	brseq_tgt_t   tgt;
	int           nErrors, nCompared, cycles, i, n;

	branch_sequencer DUT (.sys_clk(sys_clk), .rst(rst), .adr_i(wbAdr), .dat_i(wbDw),
		.dat_o(wbDr), .we_i(wbWe), .sel_i(wbSel), .stb_i(wbStb), .cyc_i(wbCyc), .ack_o(wbAck),
		.issueValid(issueValid), .issueInstr(issueInstr), .issueAddr(issueAddr),
		.fmLinkValid(fmLinkValid), .fmFirstHalf(fmHalf), .interchipA(icA), .interchipB(icB),
		.coprocInBusy(cinB), .coprocOutReady(coutR), .assignedCell(acf), .schedBusy(sched),
		.sparseEvents(sparse), .transmitFullCount(txf), .receiveBusyCount(rxb),
		.dmaOutBusy(dOut), .dmaQueueBusy(dQ), .decideValid(decideValid), .slotAddr(slotAddr),
		.slotExecute(slotExecute), .branchTaken(branchTaken), .fetchAddr(fetchAddr),
		.csoValid(csoValid), .csoCode(csoCode));

	brseq_pipe_model PIPE (.sys_clk(sys_clk), .rst(rst), .reqValid(reqValid),
		.reqInstr(reqInstr), .reqAddr(reqAddr), .fmReq(fmReq), .fmData(fmData),
		.issueValid(issueValid), .issueInstr(issueInstr), .issueAddr(issueAddr),
		.fmLinkValid(fmLinkValid), .fmFirstHalf(fmHalf));

	task automatic printVerdict();
		$display("compared %0d, errors %0d", nCompared, nErrors);
		if (nErrors == 0 && nCompared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input brseq_word_t got, input brseq_word_t exp, input string what);
		nCompared++;
		if (got !== exp) begin
			nErrors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input brseq_word_t d,
		input logic [3:0] sl);
		@(posedge sys_clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbDw <= d;
		wbSel <= sl;
		do @(posedge sys_clk);
		while (wbAck !== 1'b1);
		q = wbDr;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input brseq_word_t exp, input string what);
		wb(1'b0, a, 32'h0, 4'hf);
		chk(q, exp, what);
	endtask

	function automatic brseq_ess_t essExp();
		essExp = {1'b0, dQ[1], dQ[0], dOut[1] | dQ[1], dOut[0] | dQ[0], txf == 4'hf,
			rxb != 4'h0, |sparse, coutR, cinB, sched, acf, rxb >= 4'h4, txf <= 4'h2, icB, icA};
	endfunction

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			nErrors++;
			printVerdict();
		end
	end

	initial begin
		void'($urandom(32'he180));
		{rst, wbWe, wbStb, wbCyc, reqValid, fmReq} = 6'h20;
		{icA, icB, cinB, coutR, acf, sched} = 6'h00;
		wbAdr = 8'h00;
		wbSel = 4'h0;
		wbDw = 32'h0;
		reqInstr = 32'h0;
		reqAddr = 17'h0;
		{fmData, sparse, txf, rxb, dOut, dQ} = 44'h0;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		rd(8'h00, 32'h0, "segment reset");
		rd(8'h04, 32'h0, "shadow reset");
		rd(8'h08, 32'h0, "link reset");
		wb(1'b1, 8'h20, 32'hffffffff, 4'hf);
		rd(8'h20, 32'h0, "unmapped");
		wb(1'b1, 8'h0c, 32'hffffffff, 4'hf);
		wb(1'b1, 8'h00, 32'hffffffff, 4'hf);
		rd(8'h00, 32'h1f, "segment width");
		wb(1'b1, 8'h00, 32'h3, 4'h0);
		rd(8'h00, 32'h1f, "no lane");
		{seg, linkV, shadowV} = {5'h1f, 33'h0};
		for (n = 0; n < 192; n++) begin
			if (n % 11 == 3) begin
				seg = 5'($urandom);
				wb(1'b1, 8'h00, {27'h0, seg}, 4'hf);
			end
			if (n % 7 == 2) begin
				linkV = 17'($urandom);
				wb(1'b1, 8'h08, {15'h0, linkV}, 4'hf);
			end
			if (n % 5 == 1) begin
				shadowV = 16'($urandom);
				@(posedge sys_clk);
				fmReq <= 1'b1;
				fmData <= shadowV;
				@(posedge sys_clk);
				fmReq <= 1'b0;
			end
			if (n % 9 == 4) begin
				rd(8'h08, {15'h0, linkV}, "link");
				rd(8'h04, {16'h0, shadowV}, "shadow");
				rd(8'h00, {27'h0, seg}, "segment");
			end
			@(posedge sys_clk);
			{icA, icB, cinB, coutR, acf, sched, dOut, dQ} <= 10'($urandom);
			txf <= 4'($urandom);
			rxb <= 4'($urandom);
			sparse <= ($urandom % 2) ? 16'h0 : 16'h1 << ($urandom % 16);
			@(posedge sys_clk);
			ev = essExp();
			rd(8'h0c, {16'h0, ev}, "state bits");
			condition_select = 4'(n % 16);
			k = 3'((n / 16) % 6);
			{s, c, cso, tgt} = {2'($urandom), ($urandom % 2) ? 8'h0 : 8'($urandom), 12'($urandom)};
			addr = 17'($urandom);
			taken = (condition_select == 4'hf) | (ev[condition_select] == s);
			slotX = (condition_select == 4'hf) ? !c : (taken | !c);
			dest = {seg, k[2] ? linkV[11:0] : (k[1] ? shadowV[11:0] : tgt)};
			@(posedge sys_clk);
			reqValid <= 1'b1;
			reqInstr <= {6'h20 + 6'(k), condition_select, s, c, cso, tgt};
			reqAddr <= addr;
			@(posedge sys_clk);
			reqValid <= 1'b0;
			i = 0;
			do begin
				@(posedge sys_clk);
				i++;
			end while (decideValid !== 1'b1 && i < 4);
			chk(32'(i), 32'h2, "decision delay");
			chk(32'(slotAddr), 32'(addr + 17'h1), "slot address");
			chk(32'(branchTaken), 32'(taken), "taken");
			chk(32'(slotExecute), 32'(slotX), "slot execute");
			chk(32'(fetchAddr), 32'(taken ? dest : addr + 17'h2), "next fetch");
			chk(32'(csoValid), 32'(cso != 8'h0), "counter op");
			if (cso != 8'h0)
				chk(32'(csoCode), 32'(cso), "counter code");
			if (taken && k[0])
				linkV = addr + 17'h2;
			@(posedge sys_clk);
			chk(32'(decideValid), 32'h0, "slot ignored");
			if (n % 13 == 6) begin
				dest = taken ? dest : addr + 17'h2;
				rd(8'h10, {12'h0, dest, 1'b0, slotX, taken}, "status");
			end
		end
		rd(8'h00, {27'h0, seg}, "segment kept");
		printVerdict();
	end
endmodule // tb
